// ---- qbx_port_expander.sv ----
// qbx_port_expander: 8-bit quasi-bidirectional port behind a two-wire slave
// assumes: scl, sda and port pins are asynchronous, sampled by ref_clk
// Overview of operation
// - eight pins, no direction register
// - pins high, weak pull-up after reset
// - strong pull-up on high write until scl falls
// - rw=0 address, acked data byte for pins
// - pins change only after data ack
// - write bytes until fifo full, each replaces latch
// - rw=1 address, pin levels sent per byte
// - read returns pin levels seen
// - no history of intermediate pin values
// - reset sets latches and bus machine
// - alert on any port input edge
// - alert clears on restore or access
// - write clears alert at port write pulse
// - read clears alert at read pulse
// - changes during clearing may be missed
// - start, stop, stable sda when scl high
// - every byte followed by ack bit
// - acker holds sda low across ack high
// - master nack ends read, slave releases
// - general call 06h then stop resets
`timescale 1ns/1ps
`default_nettype none
module qbx_port_expander
  import qbx_pkg::*;
(
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  // two-wire bus
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe,
  // port pins
  input  wire logic [QBX_PORT_W-1:0] port_pins_i,
  output logic [QBX_PORT_W-1:0]      port_pins_o,
  output logic [QBX_PORT_W-1:0]      port_pins_oe,
  output logic [QBX_PORT_W-1:0]      strong_pullup_pulse,
  // alert, open drain, active low
  output logic                       alert_n_o,
  output logic                       alert_n_oe,
  // stream of written bytes
  output logic                       wr_valid,
  input  wire logic                  wr_ready,
  output logic [QBX_FIFO_W-1:0]      wr_data
);
  // synchronisers
  logic [1:0]            scl_s_q, sda_s_q;
  logic [QBX_PORT_W-1:0] pin_m_q, pin_s_q;
  logic                  scl_p_q, sda_p_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      pin_m_q <= QBX_PORT_RST;
      pin_s_q <= QBX_PORT_RST;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
      pin_m_q <= port_pins_i;
      pin_s_q <= pin_m_q;
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
    end
  end

  logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
  assign scl      = scl_s_q[1];
  assign sda      = sda_s_q[1];
  assign scl_rise = scl && !scl_p_q;
  assign scl_fall = !scl && scl_p_q;
  assign start_c  = scl && scl_p_q && sda_p_q && !sda;
  assign stop_c   = scl && scl_p_q && !sda_p_q && sda;

  // bus state machine
  qbx_state_t            st_q, st_d;
  logic [3:0]            bit_q, bit_d;
  logic [7:0]            sh_q, sh_d;
  logic                  rw_q, rw_d;
  logic                  gc_q, gc_d;
  logic                  swrst_q, swrst_d;
  logic                  drv_q, drv_d;
  logic                  ack_is_data_q, ack_is_data_d;
  logic [QBX_PORT_W-1:0] latch_q, latch_d;
  logic [QBX_PORT_W-1:0] spu_q, spu_d;
  logic                  wpulse_q, wpulse_d;
  logic                  rpulse_q, rpulse_d;
  logic                  soft_rst;
  logic                  push_v, push_r;

  always_comb begin
    st_d     = st_q;
    bit_d    = bit_q;
    sh_d     = sh_q;
    rw_d     = rw_q;
    gc_d     = gc_q;
    swrst_d  = swrst_q;
    drv_d    = drv_q;
    latch_d  = latch_q;
    spu_d    = spu_q;
    wpulse_d = 1'b0;
    rpulse_d = 1'b0;
    soft_rst = 1'b0;
    if (scl_fall) begin
      spu_d = '0;
    end
    if (stop_c) begin
      soft_rst = swrst_q;
      st_d     = QBX_IDLE;
      drv_d    = 1'b0;
      swrst_d  = 1'b0;
    end else if (start_c) begin
      st_d    = QBX_ADDR;
      bit_d   = 4'h0;
      drv_d   = 1'b0;
      swrst_d = 1'b0;
    end else begin
      unique case (st_q)
        QBX_IDLE, QBX_IGNORE: begin
          drv_d = 1'b0;
        end
        QBX_ADDR, QBX_WDATA: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda};
            bit_d = bit_q + 4'h1;
          end
          if (scl_fall && bit_q == 4'h8) begin
            bit_d = 4'h0;
            st_d  = QBX_ACK;
            if (st_q == QBX_ADDR) begin
              rw_d = sh_q[0];
              gc_d = (sh_q[7:1] == QBX_GCALL_ADDR) && !sh_q[0];
              if ((sh_q[7:1] == QBX_SLV_ADDR) || gc_d) begin
                drv_d = 1'b1;
              end else begin
                st_d = QBX_IGNORE;
              end
            end else if (gc_q) begin
              swrst_d = (sh_q == QBX_SWRST_BYTE) && !swrst_q;
              drv_d   = swrst_d;
              if (!swrst_d) begin
                st_d = QBX_IGNORE;
              end
            end else begin
              // full fifo: byte refused, no ack, port untouched
              drv_d = push_r;
              if (!push_r) begin
                st_d = QBX_IGNORE;
              end
            end
          end
        end
        QBX_ACK: begin
          // ack held low across the whole scl high phase
          if (scl_fall) begin
            drv_d = 1'b0;
            if (rw_q) begin
              st_d     = QBX_RDATA;
              sh_d     = pin_s_q;
              rpulse_d = 1'b1;
              drv_d    = !pin_s_q[7];
              bit_d    = 4'h1;
            end else begin
              st_d = QBX_WDATA;
            end
          end
        end
        QBX_RDATA: begin
          if (scl_fall) begin
            if (bit_q == 4'h8) begin
              drv_d = 1'b0;
              st_d  = QBX_RACK;
            end else begin
              drv_d = !sh_q[7 - bit_q[2:0]];
              bit_d = bit_q + 4'h1;
            end
          end
        end
        QBX_RACK: begin
          if (scl_rise) begin
            bit_d = 4'h0;
            st_d  = sda ? QBX_IGNORE : QBX_ACK;
          end
        end
        default: st_d = QBX_IDLE;
      endcase
    end
    // data byte acked: drive pins on ack release
    if (st_q == QBX_ACK && scl_fall && !rw_q && !gc_q && ack_is_data_q) begin
      latch_d  = sh_q;
      spu_d    = sh_q;
      wpulse_d = 1'b1;
    end
  end

  // distinguishes data ack from address ack
  always_comb begin
    ack_is_data_d = ack_is_data_q;
    if (start_c || stop_c) begin
      ack_is_data_d = 1'b0;
    end else if (st_q == QBX_ACK && scl_fall) begin
      ack_is_data_d = !rw_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_q          <= QBX_IDLE;
      bit_q         <= 4'h0;
      sh_q          <= 8'h00;
      rw_q          <= 1'b0;
      gc_q          <= 1'b0;
      swrst_q       <= 1'b0;
      drv_q         <= 1'b0;
      latch_q       <= QBX_PORT_RST;
      spu_q         <= '0;
      wpulse_q      <= 1'b0;
      rpulse_q      <= 1'b0;
      ack_is_data_q <= 1'b0;
    end else if (soft_rst) begin
      st_q          <= QBX_IDLE;
      bit_q         <= 4'h0;
      sh_q          <= 8'h00;
      rw_q          <= 1'b0;
      gc_q          <= 1'b0;
      swrst_q       <= 1'b0;
      drv_q         <= 1'b0;
      latch_q       <= QBX_PORT_RST;
      spu_q         <= '0;
      wpulse_q      <= 1'b0;
      rpulse_q      <= 1'b0;
      ack_is_data_q <= 1'b0;
    end else begin
      st_q          <= st_d;
      bit_q         <= bit_d;
      sh_q          <= sh_d;
      rw_q          <= rw_d;
      gc_q          <= gc_d;
      swrst_q       <= swrst_d;
      drv_q         <= drv_d;
      latch_q       <= latch_d;
      spu_q         <= spu_d;
      wpulse_q      <= wpulse_d;
      rpulse_q      <= rpulse_d;
      ack_is_data_q <= ack_is_data_d;
    end
  end

  // alert: reference snapshot taken at each access
  logic [QBX_PORT_W-1:0] ref_q, ref_d;
  logic                  alert_q, alert_d;
  logic [1:0]            wsettle_q, wsettle_d;
  logic                  snap;
  // own write reaches pin_s_q two cycles late: snapshot again then
  always_comb begin
    wsettle_d = {wsettle_q[0], wpulse_q};
    snap      = wpulse_q || rpulse_q || wsettle_q[1];
    ref_d     = ref_q;
    if (snap) begin
      ref_d = pin_s_q;
    end
    alert_d = !snap && (pin_s_q != ref_q);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ref_q     <= QBX_PORT_RST;
      alert_q   <= 1'b0;
      wsettle_q <= 2'h0;
    end else begin
      ref_q     <= ref_d;
      alert_q   <= alert_d;
      wsettle_q <= wsettle_d;
    end
  end

  // written bytes stream out through the fifo
  assign push_v = wpulse_q;
  qbx_fifo #(
    .WIDTH (QBX_FIFO_W),
    .DEPTH (QBX_FIFO_D)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .in_valid  (push_v),
    .in_ready  (push_r),
    .in_data   (latch_q),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_data)
  );

  // quasi-bidirectional pins: drive low only, no direction register
  assign port_pins_o         = '0;
  assign port_pins_oe        = ~latch_q;
  assign strong_pullup_pulse = spu_q;
  assign sda_o               = 1'b0;
  assign sda_oe              = drv_q;
  assign alert_n_o           = 1'b0;
  assign alert_n_oe          = alert_q;
endmodule
`default_nettype wire

// ---- qbx_pkg.sv ----
// qbx_pkg: constants for the quasi-bidirectional port expander
// assumes: shared by qbx_port_expander, its checker and the testbench
package qbx_pkg;
  localparam int          QBX_PORT_W     = 8;
  localparam logic [7:0]  QBX_PORT_RST   = 8'hFF;
  localparam logic [6:0]  QBX_GCALL_ADDR = 7'h00;
  localparam logic [7:0]  QBX_SWRST_BYTE = 8'h06;
  localparam logic [6:0]  QBX_SLV_ADDR   = 7'h20;
  localparam int          QBX_FIFO_W     = 8;
  localparam int          QBX_FIFO_D     = 32;
  localparam int          QBX_SYNC_LEN   = 2;

  typedef enum logic [2:0] {
    QBX_IDLE,
    QBX_ADDR,
    QBX_ACK,
    QBX_WDATA,
    QBX_RDATA,
    QBX_RACK,
    QBX_IGNORE
  } qbx_state_t;
endpackage

// ---- qbx_fifo.sv ----
// qbx_fifo: synchronous fifo with valid/ready on both sides
// assumes: single clock, asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module qbx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wp_d  = push ? wp_q + 1'b1 : wp_q;
    rp_d  = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ---- qbx_port_expander_assertions.sv ----
// checker: assertions on the port expander top ports
// assumes: one ref_clk domain, bound to every expander instance
`timescale 1ns/1ps
`default_nettype none
module qbx_port_expander_assertions
  import qbx_pkg::*;
(
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rstn,
  // bus, pins, alert, stream
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic [7:0] port_pins_i,
  input wire logic [7:0] port_pins_o,
  input wire logic [7:0] port_pins_oe,
  input wire logic [7:0] strong_pullup_pulse,
  input wire logic       alert_n_o,
  input wire logic       alert_n_oe,
  input wire logic       wr_valid,
  input wire logic       wr_ready,
  input wire logic [7:0] wr_data
);
  // cycles since the pins last moved, saturating
  logic [3:0] age_q, age_d;
  logic [7:0] seen_q;
  always_comb begin
    age_d = (age_q == 4'hF) ? age_q : age_q + 4'h1;
    if (port_pins_i != seen_q) age_d = 4'h0;
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      age_q  <= 4'hF;
      seen_q <= QBX_PORT_RST;
    end else begin
      age_q  <= age_d;
      seen_q <= port_pins_i;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_stall;
    wr_valid && !wr_ready;
  endsequence
  sda_open_drain_a: assert property (sda_o == 1'b0)
    else $error("sda data high");
  pins_open_drain_a: assert property (port_pins_o == 8'h00)
    else $error("pin data high");
  alert_open_drain_a: assert property (alert_n_o == 1'b0)
    else $error("alert data high");
  reset_quiet_a: assert property ($rose(rstn) |->
    !sda_oe && port_pins_oe == 8'h00 && !alert_n_oe && !wr_valid)
    else $error("outputs active after reset");
  pullup_high_only_a: assert property ((strong_pullup_pulse & port_pins_oe) == 8'h00)
    else $error("strong pull-up on a low pin");
  pullup_off_scl_a: assert property ($fell(|strong_pullup_pulse) |-> !scl_i)
    else $error("strong pull-up off with scl high");
  sda_stable_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
    else $error("sda moved while scl high");
  alert_cause_a: assert property ($rose(alert_n_oe) |-> age_q <= 4'hC)
    else $error("alert without a pin edge");
  stream_hold_a: assert property (s_stall |=> wr_valid && $stable(wr_data))
    else $error("stream byte dropped while stalled");
endmodule
bind qbx_port_expander qbx_port_expander_assertions u_chk (
  .ref_clk, .rstn, .scl_i, .sda_i, .sda_o, .sda_oe, .port_pins_i, .port_pins_o,
  .port_pins_oe, .strong_pullup_pulse, .alert_n_o, .alert_n_oe, .wr_valid,
  .wr_ready, .wr_data
);
`default_nettype wire

// ---- qbx_i2c_master.sv ----
// qbx_i2c_master: behavioural two-wire bus master
// assumes: sda_line is the wired-and line with a pull-up
`timescale 1ns/1ps
`default_nettype none
module qbx_i2c_master #(
  parameter int Q = 12
) (
  // bus lines, 1 = released
  output logic      scl,
  output logic      sda_rel,
  input  wire logic sda_line
);
  initial begin
    scl     = 1'b1;
    sda_rel = 1'b1;
  end
  // data moves only while scl is low
  task automatic bit_io(input logic b, output logic r);
    sda_rel = b;
    #Q scl = 1'b1;
    #Q r = sda_line;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic start();
    sda_rel = 1'b1;
    #Q scl = 1'b1;
    #Q sda_rel = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_rel = 1'b0;
    #Q scl = 1'b1;
    #Q sda_rel = 1'b1;
    #Q;
  endtask
  // ack_in low holds sda down over the whole ack pulse
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(ack_in, ack);
  endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// testbench: port expander driven through a bus master model
// assumes: package, design, model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench
  import qbx_pkg::*;
;
  logic       ref_clk, rstn, sda_o, sda_oe, alert_n_o, alert_n_oe;
  logic       scl, sda_rel, wr_valid, wr_ready, stall, a;
  logic [7:0] wr_data, port_pins_o, port_pins_oe, strong_pullup_pulse;
  logic [7:0] ext, r, v;
  logic [7:0] q[$];
  int         fails, checked;
  wire        sda_line = sda_rel & ~sda_oe;
  wire  [7:0] port_pins_i = ext & ~port_pins_oe;
  qbx_port_expander u_qbx_port_expander (
    .ref_clk, .rstn, .scl_i(scl), .sda_i(sda_line), .sda_o, .sda_oe,
    .port_pins_i, .port_pins_o, .port_pins_oe, .strong_pullup_pulse,
    .alert_n_o, .alert_n_oe, .wr_valid, .wr_ready, .wr_data
  );
  qbx_i2c_master u_qbx_i2c_master (.scl, .sda_rel, .sda_line);
  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;
  always begin
    @(posedge ref_clk);
    #1 wr_ready = !stall && ($urandom % 4 != 0);
  end
  always @(posedge ref_clk) begin
    if (rstn === 1'b1 && wr_valid === 1'b1 && wr_ready === 1'b1) begin
      chk(wr_data, q.size() ? q.pop_front() : 8'hXX);
    end
  end
  task chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task tally_and_finish();
    $display("compares %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wb(input logic [7:0] d, input logic e);
    u_qbx_i2c_master.xfer(d, 1'b1, r, a);
    chk({7'h00, a}, {7'h00, e});
  endtask
  task rb(input logic [7:0] e, input logic last);
    u_qbx_i2c_master.xfer(8'hFF, last, r, a);
    chk(r, e);
  endtask
  task wp(input logic [7:0] d);
    u_qbx_i2c_master.start();
    wb(8'h40, 1'b0);
    q.push_back(d);
    wb(d, 1'b0);
    u_qbx_i2c_master.stop();
  endtask
  initial begin
    #100_000;
    fails++;
    tally_and_finish();
  end
  initial begin
    rstn = 1'b0;
    stall = 1'b0;
    ext = 8'hFF;
    fails = 0;
    checked = 0;
    v = 8'($urandom(67652));
    repeat (4) @(posedge ref_clk);
    #1 rstn = 1'b1;
    #20;
    chk(port_pins_oe, 8'h00);
    u_qbx_i2c_master.start();
    wb(8'h40, 1'b0);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      q.push_back(v);
      wb(v, 1'b0);
      #25;
      chk(port_pins_oe, ~v);
      chk(strong_pullup_pulse, v);
    end
    u_qbx_i2c_master.stop();
    u_qbx_i2c_master.start();
    wb(8'h42, 1'b1);
    wb(8'h00, 1'b1);
    u_qbx_i2c_master.stop();
    chk(port_pins_oe, ~v);
    wp(8'hF0);
    ext = 8'($urandom) | 8'h0F;
    #100;
    u_qbx_i2c_master.start();
    wb(8'h41, 1'b0);
    rb(ext & 8'hF0, 1'b0);
    rb(ext & 8'hF0, 1'b1);
    u_qbx_i2c_master.stop();
    #25;
    chk({7'h00, alert_n_oe}, 8'h00);
    for (int i = 0; i < 3; i++) begin
      ext[4] = ~ext[4];
      #100;
      chk({7'h00, alert_n_oe}, {7'h00, i != 1});
    end
    wp(8'hF0);
    #25;
    chk({7'h00, alert_n_oe}, 8'h00);
    for (int i = 0; i < 2; i++) begin
      u_qbx_i2c_master.start();
      wb(8'h00, 1'b0);
      wb(i ? 8'h06 : 8'h07, i == 0);
      u_qbx_i2c_master.stop();
      #25;
      chk(port_pins_oe, i ? 8'h00 : 8'h0F);
    end
    stall = 1'b1;
    #200;
    u_qbx_i2c_master.start();
    wb(8'h40, 1'b0);
    for (int i = 0; i < 33; i++) begin
      v = 8'($urandom);
      v[1] = v[0];
      if (i < 32) q.push_back(v);
      wb(v, i == 32);
    end
    u_qbx_i2c_master.stop();
    chk(port_pins_oe, ~q[$]);
    stall = 1'b0;
    repeat (300) @(posedge ref_clk);
    chk(8'(q.size()), 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
